/* core/close_onto_fault_guard.sv */
// close-onto-fault guard with wishbone registers, events and interrupt
`timescale 1ns/100ps
module close_onto_fault_guard #(
  parameter int unsigned TICK_CYC = cof_pkg::TICK_CYC
) (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // wishbone slave
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [7:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic [31:0]      dat_o,
  output logic             ack_o,
  // binary signals from the far side
  input  wire logic        guard_arm_input_i,
  input  wire logic        guard_block_input_i,
  input  wire logic        protection_start_input_i,
  input  wire logic        grp_sel_i,
  // guard outputs
  output logic             guard_trip_output_o,
  output logic             guard_active_output_o,
  output logic [3:0]       ev_on_o,
  output logic [3:0]       ev_off_o,
  output logic             irq_o
);
  initial begin
    if (TICK_CYC < 2) $error("tick must be at least two cycles");
  end

  typedef enum logic [1:0] {ST_IDLE, ST_ACTIVE, ST_TRIP} state_t;

  guard_cond_if cif ();

  // synchronisers for external binary inputs
  logic [3:0] in_s1_reg;
  logic [3:0] in_s2_reg;
  logic       arm_prev_reg;
  logic       arm_s, blk_s, fcn_s, grp_s;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      in_s1_reg <= 4'h0;
      in_s2_reg <= 4'h0;
    end else begin
      in_s1_reg <= {grp_sel_i, protection_start_input_i,
                    guard_block_input_i, guard_arm_input_i};
      in_s2_reg <= in_s1_reg;
    end
  end
  assign arm_s = in_s2_reg[0];
  assign blk_s = in_s2_reg[1];
  assign fcn_s = in_s2_reg[2];

  // registers
  logic [31:0] ctrl_reg;
  logic [31:0] rel0_reg;
  logic [31:0] rel1_reg;
  logic [31:0] time_ms_reg;
  logic [3:0]  irq_stat_reg;
  logic [3:0]  irq_en_reg;
  logic [3:0]  log_sel_reg;
  logic        wb_wr;
  logic        wb_req;
  logic        force_en;
  logic [1:0]  force_val;
  logic [31:0] rel_ms;
  logic [3:0]  ev_on_w;
  logic [3:0]  ev_off_w;
  logic [127:0] counts;
  logic [31:0] log_time, log_info, log_trem, log_elap;
  logic [3:0]  log_cnt;

  function automatic logic [31:0] merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                        input logic [3:0] be);
    logic [31:0] r;
    r = old_v;
    for (int b = 0; b < 4; b++) if (be[b]) r[b*8 +: 8] = new_v[b*8 +: 8];
    return r;
  endfunction

  function automatic logic [31:0] clamp_rel(input logic [31:0] v);
    return (v > 32'(cof_pkg::REL_MAX_MS)) ? 32'(cof_pkg::REL_MAX_MS) : v;
  endfunction

  assign wb_req = cyc_i && stb_i && !ack_o;
  assign wb_wr  = wb_req && we_i;

  always_ff @(posedge clk_i) begin
    if (rst_i) ack_o <= 1'b0;
    else ack_o <= wb_req;
  end

  // software writes
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_reg    <= cof_pkg::CTRL_RESET;
      rel0_reg    <= cof_pkg::REL_DEFAULT_MS;
      rel1_reg    <= cof_pkg::REL_DEFAULT_MS;
      irq_en_reg  <= 4'h0;
      log_sel_reg <= 4'h0;
    end else begin
      ctrl_reg[cof_pkg::CTRL_CNT_RST] <= 1'b0;
      if (wb_wr) begin
        unique case (adr_i)
          cof_pkg::OFS_CTRL:     ctrl_reg <= merge(ctrl_reg, dat_i, sel_i) & 32'h0000_013f;
          cof_pkg::OFS_REL_GRP0: rel0_reg <= clamp_rel(merge(rel0_reg, dat_i, sel_i));
          cof_pkg::OFS_REL_GRP1: rel1_reg <= clamp_rel(merge(rel1_reg, dat_i, sel_i));
          cof_pkg::OFS_IRQ_EN:   if (sel_i[0]) irq_en_reg <= dat_i[3:0];
          cof_pkg::OFS_LOG_SEL:  if (sel_i[0]) log_sel_reg <= dat_i[3:0];
          default: ;
        endcase
      end
    end
  end

  assign force_en  = ctrl_reg[cof_pkg::CTRL_FORCE_EN];
  assign force_val = ctrl_reg[cof_pkg::CTRL_FORCE_LSB +: 2];
  // group picked by pin or by software, read live every cycle
  assign grp_s  = in_s2_reg[3] | ctrl_reg[cof_pkg::CTRL_GRP_SEL];
  assign rel_ms = grp_s ? rel1_reg : rel0_reg;

  // millisecond tick and time of day counter
  logic [31:0] tick_cnt_reg;
  logic        tick;
  assign tick = (tick_cnt_reg == TICK_CYC - 1);
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tick_cnt_reg <= 32'h0;
      time_ms_reg  <= 32'h0;
    end else begin
      tick_cnt_reg <= tick ? 32'h0 : tick_cnt_reg + 32'h1;
      if (wb_wr && adr_i == cof_pkg::OFS_TIME_MS) time_ms_reg <= merge(time_ms_reg, dat_i, sel_i);
      else if (tick) time_ms_reg <= time_ms_reg + 32'h1;
    end
  end

  // guard state machine
  state_t      state_reg;
  logic [31:0] elapsed_reg;
  logic        arm_edge;
  logic        expired;
  assign arm_edge = arm_s && !arm_prev_reg;
  assign expired  = (elapsed_reg >= rel_ms);

  always_ff @(posedge clk_i) begin
    if (rst_i) arm_prev_reg <= 1'b0;
    else arm_prev_reg <= arm_s;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_reg   <= ST_IDLE;
      elapsed_reg <= 32'h0;
    end else begin
      unique case (state_reg)
        ST_IDLE: begin
          if (arm_edge && !blk_s) begin
            state_reg   <= ST_ACTIVE;
            elapsed_reg <= 32'h0;
          end
        end
        ST_ACTIVE: begin
          if (blk_s) state_reg <= ST_IDLE;
          else if (fcn_s) state_reg <= ST_TRIP;
          else if (expired) state_reg <= ST_IDLE;
          else if (tick) elapsed_reg <= elapsed_reg + 32'h1;
        end
        ST_TRIP: begin
          if (blk_s || !fcn_s) state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  // outputs with forcing; trip is combinational for zero added delay
  logic act_int, trip_int, blk_int;
  always_comb begin
    act_int  = (state_reg == ST_ACTIVE) && !blk_s && !expired;
    trip_int = ((state_reg == ST_ACTIVE) && !blk_s && !expired && fcn_s)
               || (state_reg == ST_TRIP && fcn_s && !blk_s);
    blk_int  = blk_s;
    if (force_en) begin
      unique case (force_val)
        cof_pkg::FORCE_NORMAL:  begin act_int = 1'b0; trip_int = 1'b0; blk_int = 1'b0; end
        cof_pkg::FORCE_BLOCKED: begin act_int = 1'b0; trip_int = 1'b0; blk_int = 1'b1; end
        cof_pkg::FORCE_ACTIVE:  begin act_int = 1'b1; trip_int = 1'b0; blk_int = 1'b0; end
        cof_pkg::FORCE_TRIP:    begin act_int = 1'b1; trip_int = 1'b1; blk_int = 1'b0; end
      endcase
    end
  end
  assign guard_active_output_o = act_int;
  assign guard_trip_output_o   = trip_int;

  // condition flags: init = arm input held high while not blocked
  assign cif.cond       = {trip_int, act_int, blk_int, arm_s && !blk_int};
  assign cif.trem_ms    = (state_reg == ST_ACTIVE && !expired) ? rel_ms - elapsed_reg : 32'h0;
  assign cif.elapsed_ms = elapsed_reg;
  assign cif.grp        = grp_s;

  cof_pkg::cond_t cond;
  always_comb begin
    if (trip_int) cond = cof_pkg::COND_TRIP;
    else if (blk_int) cond = cof_pkg::COND_BLOCKED;
    else if (act_int) cond = cof_pkg::COND_ACTIVE;
    else if (cif.cond[cof_pkg::EV_INIT]) cond = cof_pkg::COND_INIT;
    else cond = cof_pkg::COND_NORMAL;
  end

  guard_event_block #(
    .DEPTH(cof_pkg::LOG_DEPTH)
  ) u_evt (
    .clk_i      (clk_i),
    .rst_i      (rst_i),
    .cond_if    (cif),
    .time_ms_i  (time_ms_reg),
    .ev_on_en_i (ctrl_reg[cof_pkg::CTRL_EV_ON]),
    .ev_off_en_i(ctrl_reg[cof_pkg::CTRL_EV_OFF]),
    .cnt_rst_i  (ctrl_reg[cof_pkg::CTRL_CNT_RST]),
    .log_sel_i  (log_sel_reg),
    .ev_on_o    (ev_on_w),
    .ev_off_o   (ev_off_w),
    .counts_o   (counts),
    .log_time_o (log_time),
    .log_info_o (log_info),
    .log_trem_o (log_trem),
    .log_elap_o (log_elap),
    .log_cnt_o  (log_cnt)
  );
  assign ev_on_o  = ev_on_w;
  assign ev_off_o = ev_off_w;

  // sticky interrupt status, set wins over clear
  always_ff @(posedge clk_i) begin
    if (rst_i) irq_stat_reg <= 4'h0;
    else begin
      if (wb_wr && adr_i == cof_pkg::OFS_IRQ_CLR && sel_i[0])
        irq_stat_reg <= (irq_stat_reg & ~dat_i[3:0]) | ev_on_w;
      else irq_stat_reg <= irq_stat_reg | ev_on_w;
    end
  end
  assign irq_o = |(irq_stat_reg & irq_en_reg);

  // read data
  always_ff @(posedge clk_i) begin
    if (rst_i) dat_o <= 32'h0;
    else if (wb_req && !we_i) begin
      unique case (adr_i)
        cof_pkg::OFS_CTRL:     dat_o <= ctrl_reg;
        cof_pkg::OFS_REL_GRP0: dat_o <= rel0_reg;
        cof_pkg::OFS_REL_GRP1: dat_o <= rel1_reg;
        cof_pkg::OFS_STATUS:   dat_o <= {24'h0, state_reg == ST_TRIP, grp_s, 3'h0, cond};
        cof_pkg::OFS_TREM:     dat_o <= cif.trem_ms;
        cof_pkg::OFS_ELAPSED:  dat_o <= elapsed_reg;
        cof_pkg::OFS_IRQ_STAT: dat_o <= {28'h0, irq_stat_reg};
        cof_pkg::OFS_IRQ_EN:   dat_o <= {28'h0, irq_en_reg};
        cof_pkg::OFS_CNT_INIT: dat_o <= counts[31:0];
        cof_pkg::OFS_CNT_BLK:  dat_o <= counts[63:32];
        cof_pkg::OFS_CNT_ACT:  dat_o <= counts[95:64];
        cof_pkg::OFS_CNT_TRIP: dat_o <= counts[127:96];
        cof_pkg::OFS_TIME_MS:  dat_o <= time_ms_reg;
        cof_pkg::OFS_LOG_SEL:  dat_o <= {28'h0, log_sel_reg};
        cof_pkg::OFS_LOG_TIME: dat_o <= log_time;
        cof_pkg::OFS_LOG_INFO: dat_o <= log_info;
        cof_pkg::OFS_LOG_TREM: dat_o <= log_trem;
        cof_pkg::OFS_LOG_ELAP: dat_o <= log_elap;
        cof_pkg::OFS_LOG_CNT:  dat_o <= {28'h0, log_cnt};
        default:               dat_o <= 32'h0;
      endcase
    end
  end
endmodule

/* core/cof_pkg.sv */
// package: register map, fields, encodings and timing of the close-onto-fault guard
package cof_pkg;
  // register byte offsets (wishbone, 32-bit words)
  localparam logic [7:0] OFS_CTRL      = 8'h00;
  localparam logic [7:0] OFS_REL_GRP0  = 8'h04;
  localparam logic [7:0] OFS_REL_GRP1  = 8'h08;
  localparam logic [7:0] OFS_STATUS    = 8'h0c;
  localparam logic [7:0] OFS_TREM      = 8'h10;
  localparam logic [7:0] OFS_ELAPSED   = 8'h14;
  localparam logic [7:0] OFS_IRQ_STAT  = 8'h18;
  localparam logic [7:0] OFS_IRQ_EN    = 8'h1c;
  localparam logic [7:0] OFS_IRQ_CLR   = 8'h20;
  localparam logic [7:0] OFS_CNT_INIT  = 8'h24;
  localparam logic [7:0] OFS_CNT_BLK   = 8'h28;
  localparam logic [7:0] OFS_CNT_ACT   = 8'h2c;
  localparam logic [7:0] OFS_CNT_TRIP  = 8'h30;
  localparam logic [7:0] OFS_TIME_MS   = 8'h34;
  localparam logic [7:0] OFS_LOG_SEL   = 8'h38;
  localparam logic [7:0] OFS_LOG_TIME  = 8'h3c;
  localparam logic [7:0] OFS_LOG_INFO  = 8'h40;
  localparam logic [7:0] OFS_LOG_TREM  = 8'h44;
  localparam logic [7:0] OFS_LOG_ELAP  = 8'h48;
  localparam logic [7:0] OFS_LOG_CNT   = 8'h4c;
  // control register fields
  localparam int CTRL_FORCE_EN  = 0;
  localparam int CTRL_FORCE_LSB = 1;
  localparam int CTRL_GRP_SEL   = 3;
  localparam int CTRL_EV_ON     = 4;
  localparam int CTRL_EV_OFF    = 5;
  localparam int CTRL_CNT_RST   = 8;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0030;
  // release time in milliseconds
  localparam int unsigned REL_MAX_MS     = 1800000;
  localparam logic [31:0] REL_DEFAULT_MS = 32'h0000_03e8;
  // clock and millisecond tick
  localparam int unsigned CLK_HZ   = 50000000;
  localparam int unsigned TICK_MS  = 1;
  localparam int unsigned TICK_CYC = CLK_HZ / 1000 * TICK_MS;
  localparam int unsigned LOG_DEPTH = 12;
  // forced status codes
  typedef enum logic [1:0] {
    FORCE_NORMAL, FORCE_BLOCKED, FORCE_ACTIVE, FORCE_TRIP
  } force_t;
  // reported condition codes
  typedef enum logic [2:0] {
    COND_NORMAL, COND_INIT, COND_ACTIVE, COND_TRIP, COND_BLOCKED
  } cond_t;
  // event index: init, blocked, active, trip
  localparam int EV_INIT  = 0;
  localparam int EV_BLK   = 1;
  localparam int EV_ACT   = 2;
  localparam int EV_TRIP  = 3;
  localparam int EV_NUM   = 4;
endpackage

/* core/guard_cond_if.sv */
// interface: condition flags from the guard core to the event block
`timescale 1ns/100ps
interface guard_cond_if;
  logic [3:0]  cond;
  logic [31:0] trem_ms;
  logic [31:0] elapsed_ms;
  logic        grp;
  modport core (output cond, output trem_ms, output elapsed_ms, output grp);
  modport evt  (input cond, input trem_ms, input elapsed_ms, input grp);
endinterface

/* core/guard_event_block.sv */
// event edges, counters and twelve-entry operation log of the guard
`timescale 1ns/100ps
module guard_event_block #(
  parameter int DEPTH = 12
) (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // condition flags
  guard_cond_if.evt        cond_if,
  // control
  input  wire logic [31:0] time_ms_i,
  input  wire logic        ev_on_en_i,
  input  wire logic        ev_off_en_i,
  input  wire logic        cnt_rst_i,
  input  wire logic [3:0]  log_sel_i,
  // results
  output logic [3:0]       ev_on_o,
  output logic [3:0]       ev_off_o,
  output logic [127:0]     counts_o,
  output logic [31:0]      log_time_o,
  output logic [31:0]      log_info_o,
  output logic [31:0]      log_trem_o,
  output logic [31:0]      log_elap_o,
  output logic [3:0]       log_cnt_o
);
  initial begin
    if (DEPTH < 1 || DEPTH > 15) $error("log depth must be 1..15");
  end

  logic [3:0]  prev_reg;
  logic [3:0]  rise;
  logic [3:0]  fall;
  logic [31:0] log_time [DEPTH];
  logic [31:0] log_trem [DEPTH];
  logic [31:0] log_elap [DEPTH];
  logic [3:0]  log_info [DEPTH];
  logic [3:0]  wr_ptr_reg;
  logic [3:0]  rd_idx;

  assign rise = cond_if.cond & ~prev_reg;
  assign fall = ~cond_if.cond & prev_reg;

  always_ff @(posedge clk_i) begin
    if (rst_i) prev_reg <= 4'h0;
    else prev_reg <= cond_if.cond;
  end

  // selected direction events, one-cycle pulses
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ev_on_o  <= 4'h0;
      ev_off_o <= 4'h0;
    end else begin
      ev_on_o  <= ev_on_en_i ? rise : 4'h0;
      ev_off_o <= ev_off_en_i ? fall : 4'h0;
    end
  end

  // cumulative counters, an event in the reset cycle is still counted
  always_ff @(posedge clk_i) begin
    if (rst_i) counts_o <= '0;
    else begin
      for (int i = 0; i < 4; i++) begin
        if (rise[i]) counts_o[i*32 +: 32] <= (cnt_rst_i ? 32'h0 : counts_o[i*32 +: 32])
                                             + 32'h1;
        else if (cnt_rst_i) counts_o[i*32 +: 32] <= 32'h0;
      end
    end
  end

  // rolling log captured on activation on events
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wr_ptr_reg <= 4'h0;
      log_cnt_o  <= 4'h0;
    end else if (rise[cof_pkg::EV_ACT]) begin
      log_time[wr_ptr_reg] <= time_ms_i;
      log_info[wr_ptr_reg] <= {3'(cof_pkg::EV_ACT), cond_if.grp};
      log_trem[wr_ptr_reg] <= cond_if.trem_ms;
      log_elap[wr_ptr_reg] <= cond_if.elapsed_ms;
      wr_ptr_reg <= (wr_ptr_reg == 4'(DEPTH - 1)) ? 4'h0 : wr_ptr_reg + 4'h1;
      if (log_cnt_o != 4'(DEPTH)) log_cnt_o <= log_cnt_o + 4'h1;
    end
  end

  // log_sel 0 is newest record
  always_comb begin
    rd_idx = (wr_ptr_reg > log_sel_i) ? wr_ptr_reg - log_sel_i - 4'h1
                                      : 4'(DEPTH) + wr_ptr_reg - log_sel_i - 4'h1;
    if (log_sel_i >= log_cnt_o) begin
      log_time_o = 32'h0;
      log_info_o = 32'h0;
      log_trem_o = 32'h0;
      log_elap_o = 32'h0;
    end else begin
      log_time_o = log_time[rd_idx];
      log_info_o = {28'h0, log_info[rd_idx]};
      log_trem_o = log_trem[rd_idx];
      log_elap_o = log_elap[rd_idx];
    end
  end
endmodule

/* sim/far_side_model.sv */
// far side: breaker close command, blocking and protection starts
`timescale 1ns/100ps
module far_side_model (
  // clock
  input  wire logic clk_i,
  // binary signals toward the guard
  output logic      arm_o,
  output logic      block_o,
  output logic      start_o,
  output logic      grp_o
);
  initial begin
    {arm_o, block_o, start_o, grp_o} = 4'h0;
  end
  // close command held for some cycles
  task automatic close_cmd(input int hold);
    arm_o <= 1'b1;
    repeat (hold) @(posedge clk_i);
    arm_o <= 1'b0;
  endtask
  // protection start after a delay
  task automatic fault(input int dly, input int len);
    repeat (dly) @(posedge clk_i);
    start_o <= 1'b1;
    repeat (len) @(posedge clk_i);
    start_o <= 1'b0;
  endtask
endmodule

/* sim/guard_props.sv */
// checker: output timing of the guard tied to its causes
`timescale 1ns/100ps
module guard_props #(
  parameter int unsigned TICK_CYC = 4
) (
  // clock and reset
  input wire logic        clk_i,
  input wire logic        rst_i,
  // wishbone
  input wire logic        cyc_i,
  input wire logic        stb_i,
  input wire logic        we_i,
  input wire logic [7:0]  adr_i,
  input wire logic [31:0] dat_i,
  input wire logic        ack_o,
  // guard pins
  input wire logic        guard_arm_input_i,
  input wire logic        guard_block_input_i,
  input wire logic        protection_start_input_i,
  input wire logic        grp_sel_i,
  input wire logic        guard_trip_output_o,
  input wire logic        guard_active_output_o,
  input wire logic [3:0]  ev_on_o
);
  logic [31:0] ctrl_reg, rel0_reg, rel1_reg, cnt_reg, lim;
  logic        fz_reg, gd_reg, wr, nf;
  assign wr  = cyc_i && stb_i && we_i && !ack_o;
  assign nf  = !ctrl_reg[0] && !fz_reg;
  assign lim = ((grp_sel_i | ctrl_reg[3]) ? rel1_reg : rel0_reg) * TICK_CYC + TICK_CYC + 32'h3;
  // shadow of control and release times
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_reg <= cof_pkg::CTRL_RESET;
      rel0_reg <= cof_pkg::REL_DEFAULT_MS;
      rel1_reg <= cof_pkg::REL_DEFAULT_MS;
    end else if (wr) begin
      case (adr_i)
        cof_pkg::OFS_CTRL:     ctrl_reg <= dat_i;
        cof_pkg::OFS_REL_GRP0: rel0_reg <= dat_i;
        cof_pkg::OFS_REL_GRP1: rel1_reg <= dat_i;
        default: ;
      endcase
    end
  end
  // active length, restarted on any setting change
  always_ff @(posedge clk_i) begin
    if (rst_i || !guard_active_output_o || !nf || wr || grp_sel_i != gd_reg) begin
      cnt_reg <= 32'h0;
    end else begin
      cnt_reg <= cnt_reg + 32'h1;
    end
    gd_reg <= grp_sel_i;
    fz_reg <= ctrl_reg[0];
  end
  default clocking dc @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  property p_ack;
    cyc_i && stb_i && !ack_o |=> ack_o ##1 !ack_o;
  endproperty
  a_ack: assert property (p_ack) else $error("ack not a single pulse");
  property p_arm;
    nf && $rose(guard_active_output_o) |-> $past(guard_arm_input_i, 2)
      || $past(guard_arm_input_i, 3) || $past(guard_arm_input_i, 4);
  endproperty
  a_arm: assert property (p_arm) else $error("window opened without arming");
  property p_trip;
    nf && guard_trip_output_o |-> $past(protection_start_input_i, 2)
      || $past(protection_start_input_i, 3);
  endproperty
  a_trip: assert property (p_trip) else $error("trip without start");
  property p_win;
    nf && $rose(guard_trip_output_o) |-> guard_active_output_o || $past(guard_active_output_o);
  endproperty
  a_win: assert property (p_win) else $error("trip outside window");
  property p_rel;
    nf && guard_active_output_o |-> cnt_reg <= lim;
  endproperty
  a_rel: assert property (p_rel) else $error("window outlived release time");
  property p_blk;
    nf && $past(guard_block_input_i, 2) && $past(guard_block_input_i, 3)
      |-> !$rose(guard_active_output_o);
  endproperty
  a_blk: assert property (p_blk) else $error("window opened while blocked");
  property p_ev;
    nf && ctrl_reg[4] && $rose(guard_active_output_o) |=> ev_on_o[2];
  endproperty
  a_ev: assert property (p_ev) else $error("no active on event");
  property p_force;
    ctrl_reg[0] |-> guard_trip_output_o == (ctrl_reg[2:1] == 2'h3);
  endproperty
  a_force: assert property (p_force) else $error("forced trip mismatch");
  c_act: cover property (nf && $rose(guard_active_output_o));
  c_trip: cover property (nf && $rose(guard_trip_output_o));
  c_force: cover property (ctrl_reg[0] && ctrl_reg[2:1] == 2'h3);
endmodule

bind close_onto_fault_guard guard_props #(.TICK_CYC(TICK_CYC)) u_props (
  .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
  .adr_i(adr_i), .dat_i(dat_i), .ack_o(ack_o), .guard_arm_input_i(guard_arm_input_i),
  .guard_block_input_i(guard_block_input_i),
  .protection_start_input_i(protection_start_input_i), .grp_sel_i(grp_sel_i),
  .guard_trip_output_o(guard_trip_output_o),
  .guard_active_output_o(guard_active_output_o), .ev_on_o(ev_on_o)
);

/* sim/testbench.sv */
// testbench: guard against far-side model and scoreboard
`timescale 1ns/100ps
module testbench;
  localparam int TK = 4;
  logic        clk_i, rst_i, cyc_i, stb_i, we_i, ack_o;
  logic        arm, blk, fst, grp, trip_o, act_o, irq_o;
  logic [7:0]  adr_i;
  logic [3:0]  sel_i;
  logic [31:0] dat_i, dat_o, q;
  logic [3:0]  ev_on, ev_off;
  int          errors, n_compared, n, d, exp_act, exp_trip;
  int          on_act, off_act, on_trip;
  int          log_q[$];

  close_onto_fault_guard #(.TICK_CYC(TK)) u_dut (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
    .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .guard_arm_input_i(arm), .guard_block_input_i(blk), .protection_start_input_i(fst),
    .grp_sel_i(grp), .guard_trip_output_o(trip_o), .guard_active_output_o(act_o),
    .ev_on_o(ev_on), .ev_off_o(ev_off), .irq_o(irq_o)
  );
  far_side_model u_far (
    .clk_i(clk_i), .arm_o(arm), .block_o(blk), .start_o(fst), .grp_o(grp)
  );

  always #10 clk_i = ~clk_i;

  // event pulse tally, one count per registered pulse
  always @(posedge clk_i) begin
    if (!rst_i) begin
      on_act  <= on_act + int'(ev_on[2]);
      off_act <= off_act + int'(ev_off[2]);
      on_trip <= on_trip + int'(ev_on[3]);
    end
  end

  task automatic finish_test();
    if (errors == 0 && n_compared > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("BAD at %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] dv);
    int k;
    {cyc_i, stb_i, we_i, adr_i, dat_i} <= {2'b11, w, a, dv};
    k = 0;
    do begin
      @(posedge clk_i);
      k++;
    end while (ack_o !== 1'b1 && k < 50);
    q = dat_o;
    {cyc_i, stb_i, we_i} <= 3'b000;
    @(posedge clk_i);
    if (k == 50) begin
      errors++;
      finish_test();
    end
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    wb(1'b0, a, 32'h0);
    chk(q & m, e);
  endtask

  task automatic wait_o(input int s, input logic v);
    n = 0;
    while ((s == 1 ? trip_o : act_o) !== v && n < 400) begin
      @(posedge clk_i);
      n++;
    end
    if (n == 400) begin
      errors++;
      finish_test();
    end
  endtask

  initial begin
    clk_i = 1'b0;
    rst_i = 1'b1;
    {cyc_i, stb_i, we_i, adr_i, dat_i} = '0;
    sel_i = 4'hf;
    {errors, n_compared, exp_act, exp_trip} = '0;
    {on_act, off_act, on_trip} = '0;
    d = $urandom(32'h16d8);
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(cof_pkg::OFS_CTRL, '1, cof_pkg::CTRL_RESET);
    rd(cof_pkg::OFS_REL_GRP0, '1, cof_pkg::REL_DEFAULT_MS);
    rd(cof_pkg::OFS_STATUS, 32'h7, 32'h0);
    rd(cof_pkg::OFS_LOG_CNT, '1, 32'h0);
    wb(1'b1, 8'h80, 32'hffff_ffff);
    rd(8'h80, '1, 32'h0);
    // random data and byte enables on the enable register
    d = $urandom;
    sel_i <= 4'(d);
    wb(1'b1, cof_pkg::OFS_IRQ_EN, 32'(d >> 4));
    sel_i <= 4'hf;
    rd(cof_pkg::OFS_IRQ_EN, '1, d[0] ? 32'((d >> 4) & 15) : 32'h0);
    // long close command: window ends while arm still high
    wb(1'b1, cof_pkg::OFS_REL_GRP0, 32'h3);
    wb(1'b1, cof_pkg::OFS_IRQ_EN, 32'h4);
    fork
      u_far.close_cmd(30);
      begin
        wait_o(0, 1'b1);
        wait_o(0, 1'b0);
      end
    join
    chk(32'(n > 2 * TK && n <= 3 * TK + 3), 32'h1);
    exp_act++;
    log_q.push_back(2);
    u_far.fault(0, 6);
    chk(trip_o, 1'b0);
    chk(irq_o, 1'b1);
    rd(cof_pkg::OFS_IRQ_STAT, 32'h4, 32'h4);
    wb(1'b1, cof_pkg::OFS_IRQ_CLR, 32'hf);
    chk(irq_o, 1'b0);
    wb(1'b1, cof_pkg::OFS_IRQ_EN, 32'h0);
    repeat (3) begin
      d = $urandom % 5;
      fork
        u_far.close_cmd(3);
        u_far.fault(d, 16);
        begin
          wait_o(1, 1'b1);
          rd(cof_pkg::OFS_STATUS, 32'h7, 32'h3);
        end
      join
      exp_act++;
      exp_trip++;
      log_q.push_back(2);
      repeat (4) @(posedge clk_i);
    end
    rd(cof_pkg::OFS_CNT_TRIP, '1, 32'(exp_trip));
    rd(cof_pkg::OFS_IRQ_STAT, 32'h8, 32'h8);
    chk(irq_o, 1'b0);
    // group switch in mid-window extends it
    wb(1'b1, cof_pkg::OFS_REL_GRP1, 32'h14);
    fork
      u_far.close_cmd(3);
      begin
        wait_o(0, 1'b1);
        u_far.grp_o <= 1'b1;
        wait_o(0, 1'b0);
      end
    join
    chk(32'(n > 19 * TK && n <= 20 * TK + 3), 32'h1);
    u_far.grp_o <= 1'b0;
    exp_act++;
    log_q.push_back(2);
    u_far.block_o <= 1'b1;
    repeat (4) @(posedge clk_i);
    fork
      u_far.close_cmd(10);
      begin
        repeat (5) @(posedge clk_i);
        rd(cof_pkg::OFS_STATUS, 32'h7, 32'h4);
        chk(act_o, 1'b0);
      end
    join
    u_far.block_o <= 1'b0;
    repeat (4) @(posedge clk_i);
    // more activations than the log holds
    wb(1'b1, cof_pkg::OFS_REL_GRP0, 32'h1);
    repeat (13) begin
      u_far.close_cmd(3);
      wait_o(0, 1'b1);
      wait_o(0, 1'b0);
      exp_act++;
      log_q.push_back(2);
      if (log_q.size() > 12) begin
        log_q.pop_front();
      end
    end
    rd(cof_pkg::OFS_LOG_CNT, '1, 32'(log_q.size()));
    wb(1'b1, cof_pkg::OFS_LOG_SEL, 32'h0);
    rd(cof_pkg::OFS_LOG_INFO, 32'hf, 32'(log_q[11] << 1));
    rd(cof_pkg::OFS_CNT_ACT, '1, 32'(exp_act));
    chk(32'(on_act), 32'(exp_act));
    chk(32'(off_act), 32'(exp_act));
    chk(32'(on_trip), 32'(exp_trip));
    for (int v = 0; v < 4; v++) begin
      wb(1'b1, cof_pkg::OFS_CTRL, cof_pkg::CTRL_RESET | 32'h1 | 32'(v << 1));
      chk(trip_o, 32'(v == 3));
      chk(act_o | trip_o, 32'(v >= 2));
    end
    wb(1'b1, cof_pkg::OFS_CTRL, cof_pkg::CTRL_RESET | 32'h100);
    rd(cof_pkg::OFS_CNT_ACT, '1, 32'h0);
    rd(cof_pkg::OFS_CNT_TRIP, '1, 32'h0);
    finish_test();
  end
endmodule
